// ==== tbm_pkg.sv ====
// Constants, encodings and timing for the temperature and battery monitor.
package tbm_pkg;

  // Byte addresses of the register file.
  localparam logic [15:0] OFS_VCO_TEST = 16'h2500;
  localparam logic [15:0] OFS_LOAD = 16'h2704;
  localparam logic [15:0] OFS_TEMP_HI = 16'h2881;
  localparam logic [15:0] OFS_TEMP_LO = 16'h2882;
  localparam logic [15:0] OFS_BATT = 16'h2885;
  localparam logic [15:0] OFS_CTRL = 16'h28A0;
  localparam logic [15:0] OFS_START = 16'h28B4;

  // Field positions.
  localparam int BIT_LOAD = 3;
  localparam int BIT_BSEL = 7;
  localparam int BIT_PWR = 6;
  localparam int BIT_BATEN = 4;
  localparam int BIT_BUSY = 3;
  localparam int BIT_START = 6;
  localparam int POS_TEMP_LO = 5;

  // Values after reset.
  localparam logic [1:0] RST_VCO_TEST = 2'h0;
  localparam logic [2:0] RST_PERIOD = 3'h0;
  localparam logic RST_BIT = 1'b0;

  // Period field codes and the exponent base of the automatic period.
  localparam logic [2:0] PER_MANUAL = 3'h0;
  localparam logic [2:0] PER_LAST_TIMED = 3'h6;
  localparam logic [2:0] PER_CONT = 3'h7;
  localparam logic [3:0] PER_EXP_BASE = 4'h3;

  // Timing.
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int COMMIT_TIME_MS = 6;
  localparam int SEC_TIME_S = 1;
  localparam int COMMIT_CYCLES = COMMIT_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int SEC_CYCLES = SEC_TIME_S * CLK_FREQ_HZ;

  // Power mode codes on the mode input.
  typedef enum logic [1:0] {
    MODE_MAINS = 2'h0,
    MODE_BROWNOUT = 2'h1,
    MODE_DISPLAY = 2'h2,
    MODE_SLEEP = 2'h3
  } power_mode_e;

  // Measurement sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_FINISH = 2'h3
  } meas_state_e;

endpackage : tbm_pkg

// ==== tbm_sync3.sv ====
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
module tbm_sync3 #(
  parameter int W = 1
) (
  // Clock and synchronous-released reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and its filtered copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  // Each bit follows only once stages two and three agree.
  always_comb
  begin
    q_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (q & (s2_reg ^ s3_reg));
  end

  // Shift chain; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q <= '0;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= q_next;
    end
  end

endmodule : tbm_sync3

// ==== tbm_monitor.sv ====
// Temperature sensor and battery monitor control with register file.
// Summary of operation
// - Period 0 manual, 1-6 two^(3+n) s, 7 continuous.
// - Battery enable adds battery reading to measurement.
// - Start bit works only with period zero.
// - Start bit ignored in sleep and display modes.
// - Hardware clears start bit when measurement completes.
// - Supply select: one digital rail, zero clock battery.
// - Sleep and display modes force clock battery supply.
// - Battery select: one main, zero clock battery.
// - Nonzero oscillator test field runs oscillator continuously.
// - Result split: eight high bits, three low bits.
// - Battery reading held in read-only register.
// - Load bit loads the selected battery.
// - Load applied only in mains mode.
// - Mains, brownout manual; sleep, display use period.
// - Control byte write sets busy and locks control byte writes.
// - Temperature result is two's complement eleven bits.
`timescale 1ns/10ps
module tbm_monitor #(
  parameter int COMMIT_CYCLES = tbm_pkg::COMMIT_CYCLES,
  parameter int SEC_CYCLES = tbm_pkg::SEC_CYCLES
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Register port.
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Power mode from the supply controller.
  input wire logic [1:0] POWER_MODE,
  // Sensing front end.
  input wire logic MEAS_DONE,
  input wire logic [10:0] MEAS_TEMP,
  input wire logic [7:0] MEAS_BATT,
  output logic MEAS_REQ,
  output logic MEAS_BATT_EN,
  output logic SUPPLY_DIGITAL,
  output logic BATT_SEL_MAIN,
  output logic BATT_LOAD_ON,
  output logic VCO_FREE_RUN
);

  localparam int CW = $clog2(COMMIT_CYCLES + 1);
  localparam int PW = $clog2(SEC_CYCLES + 1);
  localparam logic [CW-1:0] COMMIT_LOAD = CW'(COMMIT_CYCLES);
  localparam logic [PW-1:0] SEC_LAST = PW'(SEC_CYCLES - 1);

  // Reset release chain.
  logic rst_meta_reg;
  logic rst_n_int;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_int <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_int <= rst_meta_reg;
    end
  end

  // Mode and done pass the three-stage synchroniser together.
  logic [2:0] sync_q;
  logic [1:0] mode;
  logic done_q;
  logic low_power;
  logic mains;

  tbm_sync3 #(
    .W(3)
  ) u_sync (
    .clk(CLK),
    .rst_n(rst_n_int),
    .d({MEAS_DONE, POWER_MODE}),
    .q(sync_q)
  );

  // Mode decode.
  always_comb
  begin
    mode = sync_q[1:0];
    done_q = sync_q[2];
    low_power = (mode == tbm_pkg::MODE_SLEEP) || (mode == tbm_pkg::MODE_DISPLAY);
    mains = (mode == tbm_pkg::MODE_MAINS);
  end

  // Control state.
  logic [1:0] test_reg, test_next;
  logic load_reg, load_next;
  logic bsel_reg, bsel_next;
  logic pwr_reg, pwr_next;
  logic baten_reg, baten_next;
  logic [2:0] per_reg, per_next;
  logic start_reg, start_next;
  logic [CW-1:0] commit_reg, commit_next;
  logic busy;
  logic start_ok;
  logic wr_start;
  logic meas_end;
  tbm_pkg::meas_state_e state_reg, state_next;

  // Register writes, commit lockout and start handling.
  always_comb
  begin
    test_next = test_reg;
    load_next = load_reg;
    bsel_next = bsel_reg;
    pwr_next = pwr_reg;
    baten_next = baten_reg;
    per_next = per_reg;
    start_next = start_reg;
    commit_next = commit_reg;
    busy = (commit_reg != '0);
    start_ok = (per_reg == tbm_pkg::PER_MANUAL) && !low_power;
    wr_start = WR && (ADDR == tbm_pkg::OFS_START) && start_ok;
    meas_end = (state_reg == tbm_pkg::ST_RUN) && done_q;
    if (busy)
    begin
      commit_next = commit_reg - CW'(1);
    end
    if (WR && (ADDR == tbm_pkg::OFS_VCO_TEST))
    begin
      test_next = WDATA[1:0];
    end
    if (WR && (ADDR == tbm_pkg::OFS_LOAD))
    begin
      load_next = WDATA[tbm_pkg::BIT_LOAD];
    end
    if (WR && (ADDR == tbm_pkg::OFS_CTRL) && !busy)
    begin
      bsel_next = WDATA[tbm_pkg::BIT_BSEL];
      pwr_next = WDATA[tbm_pkg::BIT_PWR];
      baten_next = WDATA[tbm_pkg::BIT_BATEN];
      per_next = WDATA[2:0];
      commit_next = COMMIT_LOAD;
    end
    if (meas_end)
    begin
      start_next = 1'b0;
    end
    if (wr_start)
    begin
      start_next = WDATA[tbm_pkg::BIT_START];
    end
  end

  always_ff @(posedge CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      test_reg <= tbm_pkg::RST_VCO_TEST;
      load_reg <= tbm_pkg::RST_BIT;
      bsel_reg <= tbm_pkg::RST_BIT;
      pwr_reg <= tbm_pkg::RST_BIT;
      baten_reg <= tbm_pkg::RST_BIT;
      per_reg <= tbm_pkg::RST_PERIOD;
      start_reg <= tbm_pkg::RST_BIT;
      commit_reg <= '0;
    end
    else
    begin
      test_reg <= test_next;
      load_reg <= load_next;
      bsel_reg <= bsel_next;
      pwr_reg <= pwr_next;
      baten_reg <= baten_next;
      per_reg <= per_next;
      start_reg <= start_next;
      commit_reg <= commit_next;
    end
  end

  // Automatic period timer.
  logic [PW-1:0] pre_reg, pre_next;
  logic [9:0] sec_reg, sec_next;
  logic due_reg, due_next;
  logic timed;
  logic cont;
  logic [9:0] sec_limit;
  logic [3:0] exp_sel;

  // Seconds prescaler and period compare; timed wakes only in low power.
  always_comb
  begin
    pre_next = pre_reg;
    sec_next = sec_reg;
    due_next = due_reg;
    exp_sel = tbm_pkg::PER_EXP_BASE + {1'b0, per_reg};
    sec_limit = 10'((11'h001 << exp_sel) - 11'h001);
    timed = low_power && (per_reg != tbm_pkg::PER_MANUAL)
      && (per_reg <= tbm_pkg::PER_LAST_TIMED);
    cont = low_power && (per_reg == tbm_pkg::PER_CONT);
    if (!timed)
    begin
      pre_next = '0;
      sec_next = '0;
      due_next = 1'b0;
    end
    else
    begin
      if (pre_reg == SEC_LAST)
      begin
        pre_next = '0;
        if (sec_reg >= sec_limit)
        begin
          sec_next = '0;
          due_next = 1'b1;
        end
        else
        begin
          sec_next = sec_reg + 10'h001;
        end
      end
      else
      begin
        pre_next = pre_reg + PW'(1);
      end
      // The wake request is consumed once the sequencer has launched; a new period end wins.
      if ((state_reg == tbm_pkg::ST_RUN) && !((pre_reg == SEC_LAST) && (sec_reg >= sec_limit)))
      begin
        due_next = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      pre_reg <= '0;
      sec_reg <= '0;
      due_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_next;
      sec_reg <= sec_next;
      due_reg <= due_next;
    end
  end

  // Measurement sequencer and result registers.
  logic run_bat_reg, run_bat_next;
  logic [10:0] temp_reg, temp_next;
  logic [7:0] batt_reg, batt_next;

  // Request, wait for done, capture temperature and, if enabled, battery in one edge, wait done low.
  always_comb
  begin
    state_next = state_reg;
    run_bat_next = run_bat_reg;
    temp_next = temp_reg;
    batt_next = batt_reg;
    unique case (state_reg)
      tbm_pkg::ST_IDLE:
      begin
        if ((start_reg && start_ok) || due_reg || cont)
        begin
          state_next = tbm_pkg::ST_RUN;
          run_bat_next = baten_reg;
        end
      end
      tbm_pkg::ST_RUN:
      begin
        if (done_q)
        begin
          state_next = tbm_pkg::ST_FINISH;
          temp_next = MEAS_TEMP;
          if (run_bat_reg)
          begin
            batt_next = MEAS_BATT;
          end
        end
      end
      tbm_pkg::ST_FINISH:
      begin
        if (!done_q)
        begin
          state_next = tbm_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_next = tbm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      state_reg <= tbm_pkg::ST_IDLE;
      run_bat_reg <= 1'b0;
      temp_reg <= '0;
      batt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      run_bat_reg <= run_bat_next;
      temp_reg <= temp_next;
      batt_reg <= batt_next;
    end
  end

  // Registered outputs and read data.
  logic [7:0] rdata_next;
  logic req_next;
  logic bat_en_next;
  logic supply_next;
  logic load_on_next;
  logic vco_next;

  // Output decode and read multiplexer; unmapped reads return zero.
  always_comb
  begin
    req_next = (state_next == tbm_pkg::ST_RUN);
    bat_en_next = (state_next == tbm_pkg::ST_RUN) && run_bat_next;
    supply_next = pwr_reg && !low_power;
    load_on_next = load_reg && mains;
    vco_next = (test_reg != 2'h0);
    rdata_next = 8'h00;
    if (RD)
    begin
      unique case (ADDR)
        tbm_pkg::OFS_VCO_TEST: rdata_next = {6'h00, test_reg};
        tbm_pkg::OFS_LOAD: rdata_next[tbm_pkg::BIT_LOAD] = load_reg;
        tbm_pkg::OFS_TEMP_HI: rdata_next = temp_reg[10:3];
        tbm_pkg::OFS_TEMP_LO: rdata_next[7:tbm_pkg::POS_TEMP_LO] = temp_reg[2:0];
        tbm_pkg::OFS_BATT: rdata_next = batt_reg;
        tbm_pkg::OFS_CTRL:
        begin
          rdata_next[tbm_pkg::BIT_BSEL] = bsel_reg;
          rdata_next[tbm_pkg::BIT_PWR] = pwr_reg;
          rdata_next[tbm_pkg::BIT_BATEN] = baten_reg;
          rdata_next[tbm_pkg::BIT_BUSY] = busy;
          rdata_next[2:0] = per_reg;
        end
        tbm_pkg::OFS_START: rdata_next[tbm_pkg::BIT_START] = start_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      RDATA <= 8'h00;
      MEAS_REQ <= 1'b0;
      MEAS_BATT_EN <= 1'b0;
      SUPPLY_DIGITAL <= 1'b0;
      BATT_SEL_MAIN <= 1'b0;
      BATT_LOAD_ON <= 1'b0;
      VCO_FREE_RUN <= 1'b0;
    end
    else
    begin
      RDATA <= rdata_next;
      MEAS_REQ <= req_next;
      MEAS_BATT_EN <= bat_en_next;
      SUPPLY_DIGITAL <= supply_next;
      BATT_SEL_MAIN <= bsel_reg;
      BATT_LOAD_ON <= load_on_next;
      VCO_FREE_RUN <= vco_next;
    end
  end

  // Checks on the sequencer, control register and outputs.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n_int);

  a_start_needs_manual: assert property (
    (WR && ADDR == tbm_pkg::OFS_START && WDATA[6] && !start_reg && per_reg != 3'h0)
    |=> !start_reg)
    else $error("start bit taken with nonzero period");

  a_start_lowpower_ign: assert property (
    (WR && ADDR == tbm_pkg::OFS_START && WDATA[6] && !start_reg && low_power)
    |=> !start_reg)
    else $error("start bit taken in low power mode");

  a_start_clears_end: assert property (
    (meas_end && !wr_start) |=> !start_reg)
    else $error("start bit not cleared at measurement end");

  a_supply_digital_sel: assert property (
    (pwr_reg && mains) ##1 mains |-> SUPPLY_DIGITAL)
    else $error("digital supply not selected");

  a_supply_forced_batt: assert property (
    low_power |=> !SUPPLY_DIGITAL)
    else $error("digital supply used in low power mode");

  a_batt_sel_follow: assert property (
    $rose(bsel_reg) |-> !BATT_SEL_MAIN ##1 BATT_SEL_MAIN)
    else $error("battery select output lags");

  a_vco_free_run: assert property (
    (test_reg != 2'h0) |=> VCO_FREE_RUN)
    else $error("oscillator not forced on");

  a_temp_lo_layout: assert property (
    (RD && ADDR == tbm_pkg::OFS_TEMP_LO)
    |=> (RDATA[4:0] == 5'h00) && (RDATA[7:5] == $past(temp_reg[2:0])))
    else $error("low temperature byte misplaced");

  a_results_together: assert property (
    ($changed(temp_reg) || $changed(batt_reg)) |-> $past(meas_end))
    else $error("result changed outside measurement end");

  a_batt_only_enabled: assert property (
    $changed(batt_reg) |-> $past(run_bat_reg))
    else $error("battery result without battery enable");

  a_load_mains_only: assert property (
    BATT_LOAD_ON |-> $past(mains) && $past(load_reg))
    else $error("battery load outside mains mode");

  a_commit_lockout: assert property (
    (busy && WR && ADDR == tbm_pkg::OFS_CTRL) |=> $stable(per_reg) && $stable(bsel_reg))
    else $error("control byte written while busy");

  a_manual_in_mains: assert property (
    (state_reg == tbm_pkg::ST_IDLE && !low_power && !start_reg)
    |=> state_reg == tbm_pkg::ST_IDLE)
    else $error("measurement started without command");

  a_cont_restart: assert property (
    (state_reg == tbm_pkg::ST_FINISH && !done_q && cont) ##1 cont
    |=> state_reg == tbm_pkg::ST_RUN)
    else $error("continuous mode did not restart");

endmodule : tbm_monitor

// ==== temperature_battery_monitor_test.sv ====
// Self-checking testbench for the temperature and battery monitor.
`timescale 1ns/10ps
module temperature_battery_monitor_test;
  localparam int SEC_N = 20;
  localparam int COMMIT_N = 10;
  localparam int FE_LAT = 6;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic vco;
  } row_s;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [15:0] ADDR = 16'h0000;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic [1:0] POWER_MODE = 2'h0;
  logic MEAS_DONE = 1'b0;
  logic [10:0] MEAS_TEMP = 11'h5A3;
  logic [7:0] MEAS_BATT = 8'h9C;
  logic MEAS_REQ;
  logic MEAS_BATT_EN;
  logic SUPPLY_DIGITAL;
  logic BATT_SEL_MAIN;
  logic BATT_LOAD_ON;
  logic VCO_FREE_RUN;
  logic [7:0] fe_cnt = 8'h00;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int span = 0;
  int tot;
  int per_t;
  row_s rows [7] = '{'{16'h2500, 8'h01, 8'h01, 1'b1}, '{16'h2500, 8'h02, 8'h02, 1'b1},
    '{16'h2500, 8'hFF, 8'h03, 1'b1}, '{16'h2500, 8'h00, 8'h00, 1'b0},
    '{16'h2704, 8'hFF, 8'h08, 1'b0}, '{16'h2704, 8'h00, 8'h00, 1'b0},
    '{16'h1234, 8'hFF, 8'h00, 1'b0}};

  tbm_monitor #(.COMMIT_CYCLES(COMMIT_N), .SEC_CYCLES(SEC_N)) DUT (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .POWER_MODE(POWER_MODE), .MEAS_DONE(MEAS_DONE), .MEAS_TEMP(MEAS_TEMP),
    .MEAS_BATT(MEAS_BATT), .MEAS_REQ(MEAS_REQ), .MEAS_BATT_EN(MEAS_BATT_EN),
    .SUPPLY_DIGITAL(SUPPLY_DIGITAL), .BATT_SEL_MAIN(BATT_SEL_MAIN),
    .BATT_LOAD_ON(BATT_LOAD_ON), .VCO_FREE_RUN(VCO_FREE_RUN));

  // The clock toggles every half period of 5 ns.
  always #5 CLK = ~CLK;

  // Front end answers a request after a few cycles and drops done once the request ends.
  always @(posedge CLK)
  begin
    fe_cnt <= MEAS_REQ ? fe_cnt + 8'h01 : 8'h00;
    MEAS_DONE <= MEAS_REQ && (fe_cnt >= 8'(FE_LAT));
  end

  // A hang is cut short by a cycle ceiling.
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  task automatic rdchk(input string name, input logic [15:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    check(name, RDATA, exp);
  endtask : rdchk

  // Waits a bounded time for the request level and adds the cycles spent to span.
  task automatic wait_req(input logic lvl, input int lim);
    int n;
    n = 0;
    while (MEAS_REQ !== lvl && n < lim)
    begin
      @(posedge CLK);
      #1;
      n++;
    end
    span += n;
    check("meas_req", 8'(MEAS_REQ), 8'(lvl));
  endtask : wait_req

  // Confirms no request is raised over a stretch of cycles.
  task automatic hold_low(input int lim);
    logic seen;
    seen = 1'b0;
    repeat (lim)
    begin
      @(posedge CLK);
      seen = seen | MEAS_REQ;
    end
    check("no_req", 8'(seen), 8'h00);
  endtask : hold_low

  task automatic set_mode(input logic [1:0] m);
    @(posedge CLK);
    POWER_MODE <= m;
    repeat (8) @(posedge CLK);
  endtask : set_mode

  task automatic do_reset();
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (5) @(posedge CLK);
  endtask : do_reset

  task automatic measure(input logic bat);
    wr(16'h28B4, 8'h40);
    wait_req(1'b1, 10);
    check("batt_en", 8'(MEAS_BATT_EN), 8'(bat));
    rdchk("start_busy", 16'h28B4, 8'h40);
    wait_req(1'b0, 40);
    rdchk("start_done", 16'h28B4, 8'h00);
  endtask : measure

  // Main sequence: table of register cases, then the hand-written cases.
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wd);
      rdchk("reg_rw", rows[i].addr, rows[i].rd);
      check("vco", 8'(VCO_FREE_RUN), 8'(rows[i].vco));
    end
    $display("Done: register table");
    wr(16'h2500, 8'h03);
    wr(16'h2704, 8'h08);
    do_reset();
    rdchk("rst_test", 16'h2500, 8'h00);
    rdchk("rst_load", 16'h2704, 8'h00);
    rdchk("rst_ctrl", 16'h28A0, 8'h00);
    rdchk("rst_start", 16'h28B4, 8'h00);
    check("rst_vco", 8'(VCO_FREE_RUN), 8'h00);
    $display("Done: reset");
    wr(16'h28A0, 8'hD0);
    rdchk("ctrl_busy", 16'h28A0, 8'hD8);
    wr(16'h28A0, 8'h00);
    repeat (COMMIT_N + 4) @(posedge CLK);
    rdchk("ctrl_kept", 16'h28A0, 8'hD0);
    $display("Done: control commit");
    wr(16'h2704, 8'h08);
    for (int m = 0; m < 4; m++)
    begin
      set_mode(2'(m));
      check("supply", 8'(SUPPLY_DIGITAL), 8'(m < 2));
      check("load", 8'(BATT_LOAD_ON), 8'(m == 0));
      check("bsel", 8'(BATT_SEL_MAIN), 8'h01);
    end
    set_mode(2'h0);
    wr(16'h2704, 8'h00);
    $display("Done: power modes");
    measure(1'b1);
    rdchk("temp_hi", 16'h2881, 8'hB4);
    rdchk("temp_lo", 16'h2882, 8'h60);
    rdchk("batt", 16'h2885, 8'h9C);
    wr(16'h2881, 8'hFF);
    rdchk("temp_ro", 16'h2881, 8'hB4);
    MEAS_TEMP <= 11'h3FF;
    MEAS_BATT <= 8'h11;
    wr(16'h28A0, 8'hC0);
    repeat (COMMIT_N + 2) @(posedge CLK);
    measure(1'b0);
    rdchk("temp_hi2", 16'h2881, 8'h7F);
    rdchk("temp_lo2", 16'h2882, 8'hE0);
    rdchk("batt_kept", 16'h2885, 8'h9C);
    $display("Done: manual measurements");
    wr(16'h28A0, 8'h01);
    repeat (COMMIT_N + 2) @(posedge CLK);
    wr(16'h28B4, 8'h40);
    rdchk("start_per", 16'h28B4, 8'h00);
    hold_low(400);
    wr(16'h28A0, 8'h00);
    repeat (COMMIT_N + 2) @(posedge CLK);
    set_mode(2'h3);
    check("supply0", 8'(SUPPLY_DIGITAL), 8'h00);
    wr(16'h28B4, 8'h40);
    rdchk("start_sleep", 16'h28B4, 8'h00);
    hold_low(60);
    $display("Done: refused starts");
    for (int p = 1; p < 7; p++)
    begin
      per_t = (1 << (3 + p)) * SEC_N;
      wr(16'h28A0, 8'(p));
      wait_req(1'b1, 2 * per_t + 60);
      span = 0;
      wait_req(1'b0, 40);
      wait_req(1'b1, per_t + 40);
      tot = span;
      check("period", 8'(tot >= per_t - 2 && tot <= per_t + 14), 8'h01);
    end
    wr(16'h28A0, 8'h07);
    wait_req(1'b1, 12000);
    wait_req(1'b0, 40);
    wait_req(1'b1, 20);
    $display("Done: automatic periods");
    set_mode(2'h0);
    wait_req(1'b0, 40);
    hold_low(100);
    $display("Done: mains ignores period");
    print_verdict();
  end
endmodule : temperature_battery_monitor_test
